// [hw/rsq_pkg.sv]
// Package for the reset sequencer: source indices, states, port group types.
// Assumes a single 100 MHz system clock domain.
package rsq_pkg;

  localparam int unsigned NUM_SOURCES   = 9;
  localparam int unsigned SRC_POWER_ON  = 0;
  localparam int unsigned SRC_PIN       = 1;
  localparam int unsigned SRC_COMPARE   = 2;
  localparam int unsigned SRC_SOFTWARE  = 3;
  localparam int unsigned SRC_SUPPLY    = 4;
  localparam int unsigned SRC_WATCHDOG  = 5;
  localparam int unsigned SRC_CLOCK     = 6;
  localparam int unsigned SRC_FLASH     = 7;
  localparam int unsigned SRC_RTC       = 8;

  localparam int unsigned PORT_WIDTH    = 8;
  localparam int unsigned PC_WIDTH      = 16;

  localparam logic [7:0]  BOOT_SIGNATURE   = 8'hA5;
  localparam logic [15:0] RESET_VECTOR     = 16'h0000;
  localparam logic [15:0] BOOT_VECTOR_DEF  = 16'h1E00;
  localparam logic [15:0] SIG_ADDR_DEF     = 16'h1FFE;

  localparam logic [PORT_WIDTH-1:0] PORT_LATCH_RESET = 8'hFF;
  localparam logic [PORT_WIDTH-1:0] PORT_OD_RESET    = 8'hFF;

  typedef enum logic [2:0] {
    RSQ_RUN,
    RSQ_HOLD,
    RSQ_SIG_REQ,
    RSQ_SIG_WAIT,
    RSQ_RELEASE
  } rsq_state_t;

  // Conditions forced on the rest of the chip
  typedef struct packed {
    logic                  core_halt;
    logic                  reg_reset;
    logic                  por_reset;
    logic                  irq_disable;
    logic                  timer_disable;
    logic                  ram_hold;
    logic [PORT_WIDTH-1:0] port_latch;
    logic [PORT_WIDTH-1:0] port_open_drain;
    logic                  weak_pullup_en;
  } rsq_force_t;

  // Machine state set on leaving reset
  typedef struct packed {
    logic                pc_load;
    logic [PC_WIDTH-1:0] pc_value;
    logic                clk_sel_internal;
    logic                watchdog_timer_en;
    logic                boot_present;
  } rsq_exit_t;

endpackage

// [hw/rsq_cause.sv]
// Sticky record of every reset cause seen since reset_n.
// Assumes requests are synchronous to clk_sys.
`timescale 1ns/10ps
`default_nettype none
module rsq_cause (
  input  wire logic                          clk_sys,
  input  wire logic                          reset_n,
  input  wire logic                          capture,
  input  wire logic [rsq_pkg::NUM_SOURCES-1:0] request,
  output logic      [rsq_pkg::NUM_SOURCES-1:0] cause
);

  typedef struct packed {
    logic [rsq_pkg::NUM_SOURCES-1:0] cause;
  } rsq_cause_state_t;

  rsq_cause_state_t state;
  rsq_cause_state_t next_state;

  always_comb begin
    next_state = state;
    // Accumulate while held so overlapping sources are all kept
    if (capture) begin
      next_state.cause = state.cause | request;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state.cause <= 9'h001;
    end else begin
      state <= next_state;
    end
  end

  assign cause = state.cause;

endmodule
`default_nettype wire

// [hw/rsq_top.sv]
// Reset entry and exit sequencer with boot vector selection.
// Assumes reset requests are synchronous levels and the flash answers a
// signature read with a one-cycle valid pulse.
// Contract
// - Any of the nine reset sources puts the device into reset.
// - Entering reset halts the core.
// - Registers load reset values; power-on-only bits keep value otherwise.
// - Entering reset disables interrupts and timers.
// - Reset never alters on-chip RAM contents.
// - During reset port latches are one with open-drain pins.
// - Weak pull-ups are on during and after reset.
// - Supply monitor or power-on reset drives the reset pin low.
// - Watchdog reset leaves the reset pin undriven.
// - Exit clears program counter and selects internal oscillator.
// - Exit leaves watchdog timer enabled and running.
// - Bootloader present only when signature byte equals 0xA5.
// - With bootloader present, fetch starts at bootloader vector.
// - Without bootloader, execution starts at address 0x0000.
`timescale 1ns/10ps
`default_nettype none
module rsq_top #(
  parameter logic [15:0] BOOT_VECTOR = rsq_pkg::BOOT_VECTOR_DEF,
  parameter logic [15:0] SIG_ADDR    = rsq_pkg::SIG_ADDR_DEF
) (
  input  wire logic                            clk_sys,
  input  wire logic                            reset_n,
  input  wire logic                            req_power_on,
  input  wire logic                            req_pin,
  input  wire logic                            req_compare,
  input  wire logic                            req_software,
  input  wire logic                            req_supply,
  input  wire logic                            req_watchdog,
  input  wire logic                            req_clock,
  input  wire logic                            req_flash,
  input  wire logic                            req_rtc,
  input  wire logic                            sig_valid,
  input  wire logic [7:0]                      sig_data,
  output logic                                 sig_read,
  output logic      [15:0]                     sig_addr,
  output rsq_pkg::rsq_force_t                  force_out,
  output rsq_pkg::rsq_exit_t                   exit_out,
  output logic                                 external_reset_line_n_out,
  output logic                                 external_reset_line_n_oe,
  output logic      [rsq_pkg::NUM_SOURCES-1:0] reset_cause
);

  typedef struct packed {
    rsq_pkg::rsq_state_t  fsm;
    rsq_pkg::rsq_force_t  frc;
    rsq_pkg::rsq_exit_t   ext;
    logic                 sig_read;
    logic                 pin_drive;
    logic                 por_seen;
    logic                 pin_level;
    logic [15:0]          addr;
  } rsq_top_state_t;

  rsq_top_state_t state;
  rsq_top_state_t next_state;
  logic [rsq_pkg::NUM_SOURCES-1:0] request;
  logic                            any_request;

  // Gather all sources into one vector, bit order as the package indices
  assign request = {
    req_rtc,
    req_flash,
    req_clock,
    req_watchdog,
    req_supply,
    req_software,
    req_compare,
    req_pin,
    req_power_on
  };
  assign any_request = |request;

  function automatic logic is_halted(input rsq_pkg::rsq_state_t fsm);
    // Every state but RUN keeps the core stopped
    is_halted = (fsm != rsq_pkg::RSQ_RUN);
  endfunction

  function automatic logic drives_pin(input logic [rsq_pkg::NUM_SOURCES-1:0] src);
    // Only power-on and supply monitor pull the pin; watchdog does not
    drives_pin = src[rsq_pkg::SRC_POWER_ON] | src[rsq_pkg::SRC_SUPPLY];
  endfunction

  // Same forced set for every source; only the power-on bit differs
  function automatic rsq_pkg::rsq_force_t forced(input logic por);
    forced.core_halt       = 1'b1;
    forced.reg_reset       = 1'b1;
    forced.por_reset       = por;
    forced.irq_disable     = 1'b1;
    forced.timer_disable   = 1'b1;
    forced.ram_hold        = 1'b1;
    forced.port_latch      = rsq_pkg::PORT_LATCH_RESET;
    forced.port_open_drain = rsq_pkg::PORT_OD_RESET;
    forced.weak_pullup_en  = 1'b1;
  endfunction

  // One signature read per exit, then one exit cycle.
  // Any request before the exit cycle goes back to HOLD; the price is a
  // second flash read, the gain is that no short request is ever lost.
  always_comb begin
    next_state = state;
    next_state.sig_read    = 1'b0;
    next_state.ext.pc_load = 1'b0;
    // Late or short sources still widen the entry conditions
    if (is_halted(state.fsm)) begin
      next_state.por_seen      = state.por_seen | request[rsq_pkg::SRC_POWER_ON];
      next_state.frc.por_reset = next_state.por_seen;
      next_state.pin_drive     = state.pin_drive | drives_pin(request);
    end

    case (state.fsm)
      rsq_pkg::RSQ_RUN: begin
        // Entry forces everything at the same edge
        if (any_request) begin
          next_state.fsm       = rsq_pkg::RSQ_HOLD;
          next_state.por_seen  = request[rsq_pkg::SRC_POWER_ON];
          next_state.frc       = forced(request[rsq_pkg::SRC_POWER_ON]);
          next_state.pin_drive = drives_pin(request);
        end
      end
      rsq_pkg::RSQ_HOLD: begin
        // Flash is not touched until every source has dropped
        if (!any_request) begin
          next_state.fsm      = rsq_pkg::RSQ_SIG_REQ;
        end
      end
      rsq_pkg::RSQ_SIG_REQ: begin
        if (any_request) begin
          next_state.fsm      = rsq_pkg::RSQ_HOLD;
        end else begin
          next_state.sig_read = 1'b1;
          next_state.fsm      = rsq_pkg::RSQ_SIG_WAIT;
        end
      end
      rsq_pkg::RSQ_SIG_WAIT: begin
        // Flash data is trusted only on its valid pulse
        if (any_request) begin
          next_state.fsm = rsq_pkg::RSQ_HOLD;
        end else if (sig_valid) begin
          next_state.ext.boot_present = (sig_data == rsq_pkg::BOOT_SIGNATURE);
          next_state.fsm = rsq_pkg::RSQ_RELEASE;
        end
      end
      rsq_pkg::RSQ_RELEASE: begin
        if (any_request) begin
          // A pulse here is gone by the next cycle, so stay halted
          next_state.fsm                   = rsq_pkg::RSQ_HOLD;
        end else begin
          // Exit actions in one cycle, then the core runs
          next_state.ext.pc_load           = 1'b1;
          next_state.ext.pc_value          = state.ext.boot_present ?
                                             BOOT_VECTOR : rsq_pkg::RESET_VECTOR;
          next_state.ext.clk_sel_internal  = 1'b1;
          next_state.ext.watchdog_timer_en = 1'b1;
          next_state.frc.core_halt         = 1'b0;
          next_state.frc.reg_reset         = 1'b0;
          next_state.frc.por_reset         = 1'b0;
          next_state.frc.irq_disable       = 1'b0;
          next_state.frc.timer_disable     = 1'b0;
          next_state.frc.ram_hold          = 1'b0;
          next_state.frc.weak_pullup_en    = 1'b1;
          next_state.pin_drive             = 1'b0;
          next_state.por_seen              = 1'b0;
          next_state.fsm                   = rsq_pkg::RSQ_RUN;
        end
      end
      default: begin
        next_state.fsm = rsq_pkg::RSQ_HOLD;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      // Asynchronous reset counts as power-on
      state.fsm                   <= rsq_pkg::RSQ_HOLD;
      state.frc.core_halt         <= 1'b1;
      state.frc.reg_reset         <= 1'b1;
      state.frc.por_reset         <= 1'b1;
      state.frc.irq_disable       <= 1'b1;
      state.frc.timer_disable     <= 1'b1;
      state.frc.ram_hold          <= 1'b1;
      state.frc.port_latch        <= rsq_pkg::PORT_LATCH_RESET;
      state.frc.port_open_drain   <= rsq_pkg::PORT_OD_RESET;
      state.frc.weak_pullup_en    <= 1'b1;
      state.ext.pc_load           <= 1'b0;
      state.ext.pc_value          <= rsq_pkg::RESET_VECTOR;
      state.ext.clk_sel_internal  <= 1'b1;
      state.ext.watchdog_timer_en <= 1'b1;
      state.ext.boot_present      <= 1'b0;
      state.sig_read              <= 1'b0;
      state.pin_drive             <= 1'b1;
      state.por_seen              <= 1'b1;
      state.pin_level             <= 1'b0;
      state.addr                  <= SIG_ADDR;
    end else begin
      state <= next_state;
    end
  end

  // Cause record is for observation only; it never gates the exit
  rsq_cause u_cause (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .capture (is_halted(state.fsm) | any_request),
    .request (request),
    .cause   (reset_cause)
  );

  assign force_out                 = state.frc;
  assign exit_out                  = state.ext;
  assign sig_read                  = state.sig_read;
  // Fixed address and pin level still come from flops, like every output
  assign sig_addr                  = state.addr;
  // Open-drain pin: level stays low, only the enable moves
  assign external_reset_line_n_out = state.pin_level;
  assign external_reset_line_n_oe  = state.pin_drive;

endmodule
`default_nettype wire

// [verification/rsq_top_assertions.sv]
// Port checker for the reset sequencer.
// Assumes it is bound onto rsq_top in the single clk_sys domain.
`timescale 1ns/10ps
`default_nettype none
module rsq_top_assertions #(
  parameter logic [15:0] BOOT_VECTOR = 16'h1E00
) (
  input wire logic                clk_sys,
  input wire logic                reset_n,
  input wire logic                req_power_on,
  input wire logic                req_pin,
  input wire logic                req_compare,
  input wire logic                req_software,
  input wire logic                req_supply,
  input wire logic                req_watchdog,
  input wire logic                req_clock,
  input wire logic                req_flash,
  input wire logic                req_rtc,
  input wire logic                sig_valid,
  input wire logic [7:0]          sig_data,
  input wire logic                sig_read,
  input wire rsq_pkg::rsq_force_t force_out,
  input wire rsq_pkg::rsq_exit_t  exit_out,
  input wire logic                external_reset_line_n_out,
  input wire logic                external_reset_line_n_oe
);
  wire logic any_req = req_power_on | req_pin | req_compare | req_software | req_supply
                     | req_watchdog | req_clock | req_flash | req_rtc;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  AST_HALT: assert property (any_req |-> ##[1:3] force_out.core_halt)
    else $error("request did not halt core");
  // Three edges so a request landing in the exit cycle is not misjudged
  AST_HOLD: assert property (any_req [*3] |-> force_out.core_halt)
    else $error("core released while request held");
  AST_FORCE: assert property (force_out.core_halt |-> force_out.reg_reset && force_out.ram_hold
    && force_out.irq_disable && force_out.timer_disable
    && force_out.port_latch == 8'hFF && force_out.port_open_drain == 8'hFF)
    else $error("forced conditions missing during reset");
  AST_PULLUP: assert property (force_out.weak_pullup_en)
    else $error("weak pullup off");
  AST_PIN: assert property ((req_power_on || req_supply) |-> ##[1:3]
    (external_reset_line_n_oe && !external_reset_line_n_out))
    else $error("reset pin not driven low");
  AST_POR: assert property ($rose(force_out.core_halt) |->
    force_out.por_reset == $past(req_power_on))
    else $error("power-on bit wrong at entry");
  AST_WATCHDOG_PIN: assert property ($rose(force_out.core_halt) && !$past(req_power_on)
    && !$past(req_supply) |-> !external_reset_line_n_oe)
    else $error("reset pin driven by other source");
  AST_EXIT: assert property (exit_out.pc_load |-> exit_out.clk_sel_internal
    && exit_out.watchdog_timer_en && !force_out.core_halt && !external_reset_line_n_oe)
    else $error("exit state wrong");
  AST_VECTOR: assert property (exit_out.pc_load |-> exit_out.pc_value ==
    (exit_out.boot_present ? BOOT_VECTOR : 16'h0000))
    else $error("start address wrong");
  AST_BOOT: assert property (exit_out.pc_load |-> $past(sig_valid, 2)
    && exit_out.boot_present == ($past(sig_data, 2) == 8'hA5))
    else $error("boot flag not from signature");
  AST_READ: assert property (sig_read |=> !sig_read)
    else $error("signature read not a pulse");
endmodule

bind rsq_top rsq_top_assertions #(
  .BOOT_VECTOR (BOOT_VECTOR)
) u_chk (
  .clk_sys                   (clk_sys),
  .reset_n                   (reset_n),
  .req_power_on              (req_power_on),
  .req_pin                   (req_pin),
  .req_compare               (req_compare),
  .req_software              (req_software),
  .req_supply                (req_supply),
  .req_watchdog              (req_watchdog),
  .req_clock                 (req_clock),
  .req_flash                 (req_flash),
  .req_rtc                   (req_rtc),
  .sig_valid                 (sig_valid),
  .sig_data                  (sig_data),
  .sig_read                  (sig_read),
  .force_out                 (force_out),
  .exit_out                  (exit_out),
  .external_reset_line_n_out (external_reset_line_n_out),
  .external_reset_line_n_oe  (external_reset_line_n_oe)
);
`default_nettype wire

// [verification/rsq_flash_model.sv]
// Flash signature store: answers each read after a set delay.
// Assumes sig_read is a one-cycle pulse; data scrambles outside valid.
`timescale 1ns/10ps
`default_nettype none
module rsq_flash_model (
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  input  wire logic       sig_read,
  input  wire logic [3:0] delay,
  input  wire logic [7:0] sig_byte,
  output logic            sig_valid,
  output logic      [7:0] sig_data
);
  logic [3:0] count;
  logic       busy;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      busy <= 1'b0;
      count <= 4'h0;
      sig_valid <= 1'b0;
      sig_data <= 8'h00;
    end else begin
      sig_valid <= 1'b0;
      // Inverting each cycle so stale data never looks held
      sig_data <= ~sig_data;
      if (sig_read) begin
        busy <= 1'b1;
        count <= delay;
      end else if (busy && count != 4'h0) begin
        count <= count - 4'h1;
      end else if (busy) begin
        busy <= 1'b0;
        sig_valid <= 1'b1;
        sig_data <= sig_byte;
      end
    end
  end
endmodule
`default_nettype wire

// [verification/tb_top.sv]
// Self-checking bench for the reset sequencer.
// Assumes the flash model answers every signature read.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  localparam logic [15:0] BOOT_VEC = 16'h1E00;
  logic                clk_sys = 1'b0;
  logic                reset_n;
  logic          [8:0] req;
  logic          [3:0] dly;
  logic          [7:0] sig_byte;
  logic                sig_valid;
  logic          [7:0] sig_data;
  logic                sig_read;
  rsq_pkg::rsq_force_t force_out;
  rsq_pkg::rsq_exit_t  exit_out;
  logic                pin_oe;
  logic          [8:0] cause;
  int                  n_fail = 0;
  int                  samples_checked = 0;

  always #5 clk_sys = ~clk_sys;

  rsq_top #(.BOOT_VECTOR(BOOT_VEC)) dut (.clk_sys(clk_sys), .reset_n(reset_n),
    .req_power_on(req[0]), .req_pin(req[1]), .req_compare(req[2]), .req_software(req[3]),
    .req_supply(req[4]), .req_watchdog(req[5]), .req_clock(req[6]), .req_flash(req[7]),
    .req_rtc(req[8]), .sig_valid(sig_valid), .sig_data(sig_data), .sig_read(sig_read),
    .sig_addr(), .force_out(force_out), .exit_out(exit_out),
    .external_reset_line_n_out(), .external_reset_line_n_oe(pin_oe), .reset_cause(cause));

  rsq_flash_model u_flash (.clk_sys(clk_sys), .reset_n(reset_n), .sig_read(sig_read),
    .delay(dly), .sig_byte(sig_byte), .sig_valid(sig_valid), .sig_data(sig_data));

  task automatic check(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask

  task automatic report_and_stop();
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic finish_exit(input logic [15:0] vec);
    int n;
    n = 0;
    while (exit_out.pc_load !== 1'b1 && n < 40) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (exit_out.pc_load !== 1'b1) begin
      check(1'b0, "exit timeout");
      report_and_stop();
    end else begin
      check(exit_out.pc_value === vec, "start address");
      check(exit_out.boot_present === (vec == BOOT_VEC), "boot flag");
      check(exit_out.clk_sel_internal === 1'b1, "clock select");
      check(exit_out.watchdog_timer_en === 1'b1, "watchdog off");
      check(force_out.core_halt === 1'b0 && pin_oe === 1'b0, "not released");
      check(force_out.weak_pullup_en === 1'b1, "pullup after");
    end
  endtask

  task automatic run_reset(input logic [8:0] src, input logic [7:0] sig, input logic [3:0] d);
    sig_byte = sig;
    dly = d;
    req = src;
    repeat (3) @(posedge clk_sys);
    #1;
    check(force_out.core_halt === 1'b1, "core not halted");
    check(force_out.reg_reset === 1'b1 && force_out.ram_hold === 1'b1, "regs ram");
    check(force_out.irq_disable === 1'b1 && force_out.timer_disable === 1'b1, "irq");
    check(force_out.port_latch === 8'hFF && force_out.port_open_drain === 8'hFF, "ports");
    check(pin_oe === (src[0] | src[4]), "pin drive");
    check(force_out.por_reset === src[0], "power-on bit");
    req = '0;
    finish_exit((sig == 8'hA5) ? BOOT_VEC : 16'h0000);
  endtask

  // Watchdog alone, then supply joins and outlives it
  task automatic overlap();
    sig_byte = 8'hA5;
    req = 9'h020;
    repeat (2) @(posedge clk_sys);
    #1;
    check(pin_oe === 1'b0, "watchdog drove pin");
    req = 9'h030;
    repeat (2) @(posedge clk_sys);
    #1;
    check(pin_oe === 1'b1, "supply not driving pin");
    req = 9'h010;
    repeat (3) @(posedge clk_sys);
    #1;
    check(force_out.core_halt === 1'b1 && sig_read === 1'b0, "left hold early");
    req = '0;
    finish_exit(BOOT_VEC);
  endtask

  // Mid-run power-on reset with no request, exit without bootloader
  task automatic mid_reset();
    sig_byte = 8'h00;
    reset_n = 1'b0;
    @(posedge clk_sys);
    #1;
    check(force_out.core_halt === 1'b1 && force_out.por_reset === 1'b1, "reset entry");
    check(pin_oe === 1'b1 && sig_read === 1'b0, "reset pin");
    reset_n = 1'b1;
    finish_exit(16'h0000);
  endtask

  initial begin
    reset_n = 1'b0;
    req = '0;
    dly = 4'h0;
    sig_byte = 8'hA5;
    repeat (2) @(posedge clk_sys);
    #1;
    reset_n = 1'b1;
    run_reset(9'h001, 8'hA5, 4'h0);
    for (int i = 0; i < 9; i++) begin
      run_reset(9'h001 << i, (i % 3 == 0) ? 8'hA5 : (i % 3 == 1) ? 8'hA4 : 8'h5A,
                4'(i * 2));
    end
    check(cause === 9'h1FF, "cause record");
    overlap();
    mid_reset();
    report_and_stop();
  end
endmodule
`default_nettype wire
